// File: cte_defines.svh
`ifndef CTE_DEFINES_SVH
`define CTE_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CTE_OP_PREBYTE 8'h9e
`define CTE_OP_SOFT_TRAP 8'h83
`define CTE_OP_ACC_TO_FLAGS 8'h84
`define CTE_OP_FLAGS_TO_ACC 8'h85
`define CTE_OP_INDEX_TO_SP 8'h94
`define CTE_OP_SP_TO_INDEX 8'h95
`define CTE_OP_ACC_TO_INDEXLO 8'h97
`define CTE_OP_INDEXLO_TO_ACC 8'h9f
`define CTE_OP_WAIT 8'h8f
`define CTE_OP_ZNC_DIR 8'h3d
`define CTE_OP_ZNC_ACC 8'h4d
`define CTE_OP_ZNC_INDEXLO 8'h5d
`define CTE_OP_ZNC_OFF8 8'h6d
`define CTE_OP_ZNC_IDX 8'h7d
`define CTE_OP_MOV_DIR_TO_IDX 8'h5e
`define CTE_OP_MOV_IMM_TO_DIR 8'h6e
`define CTE_OP_MOV_IDX_TO_DIR 8'h7e
`define CTE_OP_BRANCH 8'h20

// ----------------------------------------
// Flag register layout and reset values
// ----------------------------------------
`define CTE_FLAG_V 7
`define CTE_FLAG_H 4
`define CTE_FLAG_I 3
`define CTE_FLAG_N 2
`define CTE_FLAG_Z 1
`define CTE_FLAG_C 0
`define CTE_FLAG_ONES 8'h60
`define CTE_FLAG_RST 8'h68
`define CTE_FLAG_KEEP_I 8'hf7
`define CTE_SP_RST 16'h00ff
`define CTE_ONE16 16'h0001
`define CTE_BYTE0 8'h00
`define CTE_SIGN_BIT 7

// ----------------------------------------
// Trap sequence steps
// ----------------------------------------
`define CTE_TRAP_LO 3'h0
`define CTE_TRAP_HI 3'h1
`define CTE_TRAP_X 3'h2
`define CTE_TRAP_A 3'h3
`define CTE_TRAP_F 3'h4
`define CTE_TRAP_VH 3'h5
`define CTE_TRAP_VL 3'h6
`define CTE_TRAP_END 3'h7

// ----------------------------------------
// Bus register map
// ----------------------------------------
`define CTE_A_CTRL 32'h0000_0000
`define CTE_A_STATUS 32'h0000_0004
`define CTE_A_CORE 32'h0000_0008
`define CTE_A_PC 32'h0000_000c
`define CTE_CTRL_RUN 0
`define CTE_CTRL_RST 1'b1
`define CTE_HSIZE_WORD 3'h2
`define CTE_WORD0 32'h0000_0000

`endif

// File: cte_pkg.sv
package cte_pkg;

	typedef enum logic [3:0] {
		S_FETCH, S_PRE, S_OP1, S_OP2, S_RD, S_WR, S_EXEC, S_BR, S_TRAP, S_WAIT
	} cte_state_e;

	typedef enum logic [3:0] {
		M_PC, M_SP, M_VEC_HI, M_VEC_LO, M_DIR, M_IDX, M_IDX_OFF8, M_IDX_OFF8_POSTINC,
		M_IDX_OFF16, M_SP_OFF8, M_SP_OFF16, M_EXTENDED
	} cte_mode_e;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} cte_mem_req_s;

endpackage : cte_pkg

// File: cte_ea.sv
`timescale 1ns/1ps
`include "cte_defines.svh"

module cte_ea (
	input wire cte_pkg::cte_mode_e mode_i,
	input wire logic [15:0] pc_i,
	input wire logic [15:0] sp_i,
	input wire logic [15:0] hx_i,
	input wire logic [15:0] off_i,
	input wire logic [15:0] vec_i,
	output logic [15:0] addr_o,
	output logic postinc_o
);

	// ----------------------------------------
	// Address forming
	// ----------------------------------------
	always_comb begin
		postinc_o = 1'b0;
		case (mode_i)
			cte_pkg::M_PC: addr_o = pc_i;
			cte_pkg::M_SP: addr_o = sp_i;
			cte_pkg::M_VEC_HI: addr_o = vec_i;
			cte_pkg::M_VEC_LO: addr_o = vec_i + `CTE_ONE16;
			cte_pkg::M_DIR: addr_o = {`CTE_BYTE0, off_i[7:0]};
			cte_pkg::M_IDX: addr_o = hx_i;
			cte_pkg::M_IDX_OFF8: addr_o = hx_i + {`CTE_BYTE0, off_i[7:0]};
			cte_pkg::M_IDX_OFF8_POSTINC: begin
				addr_o = hx_i + {`CTE_BYTE0, off_i[7:0]};
				postinc_o = 1'b1;
			end
			cte_pkg::M_IDX_OFF16: addr_o = hx_i + off_i;
			cte_pkg::M_SP_OFF8: addr_o = sp_i + {`CTE_BYTE0, off_i[7:0]};
			cte_pkg::M_SP_OFF16: addr_o = sp_i + off_i;
			cte_pkg::M_EXTENDED: addr_o = off_i;
			default: addr_o = pc_i;
		endcase
	end

endmodule : cte_ea

// File: cte_core.sv
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "cte_defines.svh"

module cte_core #(
	parameter logic [15:0] RESET_PC = 16'h0000,
	parameter logic [15:0] VEC_ADDR = 16'hfffc
) (
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic irq_i,
	input wire logic [7:0] mem_rdata_i,
	output cte_pkg::cte_mem_req_s mem_req_o,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o
);

	if (VEC_ADDR == 16'hffff) begin : g_bad_vec
		$error("Vector needs two bytes below the top of memory");
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic is_check_op(input logic [7:0] op);
		is_check_op = (op == `CTE_OP_ZNC_DIR) || (op == `CTE_OP_ZNC_OFF8) ||
			(op == `CTE_OP_ZNC_IDX);
	endfunction : is_check_op

	function automatic logic [7:0] check_flags(input logic [7:0] f, input logic [7:0] v);
		logic [7:0] r;
		r = f;
		r[`CTE_FLAG_V] = 1'b0;
		r[`CTE_FLAG_N] = v[`CTE_SIGN_BIT];
		r[`CTE_FLAG_Z] = (v == `CTE_BYTE0);
		check_flags = r;
	endfunction : check_flags

	// ----------------------------------------
	// Core state
	// ----------------------------------------
	cte_pkg::cte_state_e state_r, state_nxt;
	cte_pkg::cte_mode_e mode_r, mode_nxt;
	cte_pkg::cte_mem_req_s mem_q, mem_nxt;
	logic [2:0] step_r, step_nxt;
	logic [7:0] op_r, op_nxt;
	logic pre_r, pre_nxt;
	logic [15:0] pc_r, pc_nxt;
	logic [15:0] sp_r, sp_nxt;
	logic [15:0] hx_r, hx_nxt;
	logic [7:0] a_r, a_nxt;
	logic [7:0] flag_r, flag_nxt;
	logic [15:0] off_r, off_nxt;
	logic [7:0] data_r, data_nxt;
	logic run_r, run_nxt;
	logic go;
	logic done;
	logic ea_postinc;
	logic [15:0] addr_nxt;
	logic [15:0] br_target;

	assign go = ce_i && run_r;
	assign br_target = pc_r + {{8{off_r[`CTE_SIGN_BIT]}}, off_r[7:0]};

	cte_ea u_ea (
		.mode_i(mode_nxt),
		.pc_i(pc_nxt),
		.sp_i(sp_nxt),
		.hx_i(hx_nxt),
		.off_i(off_nxt),
		.vec_i(VEC_ADDR),
		.addr_o(addr_nxt),
		.postinc_o()
	);

	cte_ea u_ea_now (
		.mode_i(mode_r),
		.pc_i(pc_r),
		.sp_i(sp_r),
		.hx_i(hx_r),
		.off_i(off_r),
		.vec_i(VEC_ADDR),
		.addr_o(),
		.postinc_o(ea_postinc)
	);

	always_comb begin : core_next
		state_nxt = state_r;
		mode_nxt = mode_r;
		step_nxt = step_r;
		op_nxt = op_r;
		pre_nxt = pre_r;
		pc_nxt = pc_r;
		sp_nxt = sp_r;
		hx_nxt = hx_r;
		a_nxt = a_r;
		flag_nxt = flag_r;
		off_nxt = off_r;
		data_nxt = data_r;
		mem_nxt = mem_q;
		done = 1'b0;
		if (go) begin
			case (state_r)
				cte_pkg::S_FETCH: begin
					op_nxt = mem_rdata_i;
					pre_nxt = 1'b0;
					pc_nxt = pc_r + `CTE_ONE16;
					mem_nxt.rd = 1'b1;
					mem_nxt.wr = 1'b0;
					case (mem_rdata_i)
						`CTE_OP_PREBYTE: state_nxt = cte_pkg::S_PRE;
						`CTE_OP_ACC_TO_INDEXLO: begin
							hx_nxt = {hx_r[15:8], a_r};
							done = 1'b1;
						end
						`CTE_OP_INDEXLO_TO_ACC: begin
							a_nxt = hx_r[7:0];
							done = 1'b1;
						end
						`CTE_OP_FLAGS_TO_ACC: begin
							a_nxt = flag_r;
							done = 1'b1;
						end
						`CTE_OP_ZNC_ACC: begin
							flag_nxt = check_flags(flag_r, a_r);
							done = 1'b1;
						end
						`CTE_OP_ZNC_INDEXLO: begin
							flag_nxt = check_flags(flag_r, hx_r[7:0]);
							done = 1'b1;
						end
						`CTE_OP_WAIT: begin
							flag_nxt[`CTE_FLAG_I] = 1'b0;
							state_nxt = cte_pkg::S_WAIT;
							mem_nxt.rd = 1'b0;
						end
						`CTE_OP_ACC_TO_FLAGS, `CTE_OP_SP_TO_INDEX, `CTE_OP_INDEX_TO_SP: begin
							state_nxt = cte_pkg::S_EXEC;
							mem_nxt.rd = 1'b0;
						end
						`CTE_OP_ZNC_DIR, `CTE_OP_ZNC_OFF8, `CTE_OP_MOV_DIR_TO_IDX,
						`CTE_OP_MOV_IMM_TO_DIR, `CTE_OP_MOV_IDX_TO_DIR, `CTE_OP_BRANCH: begin
							state_nxt = cte_pkg::S_OP1;
						end
						`CTE_OP_ZNC_IDX: begin
							state_nxt = cte_pkg::S_RD;
							mode_nxt = cte_pkg::M_IDX;
						end
						`CTE_OP_SOFT_TRAP: begin
							state_nxt = cte_pkg::S_TRAP;
							step_nxt = `CTE_TRAP_LO;
							mode_nxt = cte_pkg::M_SP;
							mem_nxt.rd = 1'b0;
							mem_nxt.wr = 1'b1;
							mem_nxt.wdata = pc_nxt[7:0];
						end
						default: done = 1'b1;
					endcase
				end
				cte_pkg::S_PRE: begin
					op_nxt = mem_rdata_i;
					pre_nxt = 1'b1;
					pc_nxt = pc_r + `CTE_ONE16;
					if (mem_rdata_i == `CTE_OP_ZNC_OFF8) begin
						state_nxt = cte_pkg::S_OP1;
					end else begin
						done = 1'b1;
					end
				end
				cte_pkg::S_OP1: begin
					pc_nxt = pc_r + `CTE_ONE16;
					off_nxt = {`CTE_BYTE0, mem_rdata_i};
					data_nxt = mem_rdata_i;
					case (op_r)
						`CTE_OP_ZNC_DIR, `CTE_OP_MOV_DIR_TO_IDX: begin
							state_nxt = cte_pkg::S_RD;
							mode_nxt = cte_pkg::M_DIR;
						end
						`CTE_OP_ZNC_OFF8: begin
							state_nxt = cte_pkg::S_RD;
							mode_nxt = pre_r ? cte_pkg::M_SP_OFF8 : cte_pkg::M_IDX_OFF8;
						end
						`CTE_OP_MOV_IDX_TO_DIR: begin
							state_nxt = cte_pkg::S_RD;
							mode_nxt = cte_pkg::M_IDX;
						end
						`CTE_OP_MOV_IMM_TO_DIR: state_nxt = cte_pkg::S_OP2;
						`CTE_OP_BRANCH: begin
							state_nxt = cte_pkg::S_BR;
							mem_nxt.rd = 1'b0;
						end
						default: done = 1'b1;
					endcase
				end
				cte_pkg::S_OP2: begin
					pc_nxt = pc_r + `CTE_ONE16;
					off_nxt = {off_r[7:0], mem_rdata_i};
					state_nxt = cte_pkg::S_WR;
					mode_nxt = cte_pkg::M_DIR;
					mem_nxt.rd = 1'b0;
					mem_nxt.wr = 1'b1;
					mem_nxt.wdata = data_r;
				end
				cte_pkg::S_RD: begin
					data_nxt = mem_rdata_i;
					if (ea_postinc) begin
						hx_nxt = hx_r + `CTE_ONE16;
					end
					if (is_check_op(op_r)) begin
						flag_nxt = check_flags(flag_r, mem_rdata_i);
						done = 1'b1;
					end else if (op_r == `CTE_OP_MOV_DIR_TO_IDX) begin
						state_nxt = cte_pkg::S_WR;
						mode_nxt = cte_pkg::M_IDX;
						mem_nxt.rd = 1'b0;
						mem_nxt.wr = 1'b1;
						mem_nxt.wdata = mem_rdata_i;
					end else if (op_r == `CTE_OP_MOV_IDX_TO_DIR) begin
						state_nxt = cte_pkg::S_WR;
						mode_nxt = cte_pkg::M_DIR;
						mem_nxt.rd = 1'b0;
						mem_nxt.wr = 1'b1;
						mem_nxt.wdata = mem_rdata_i;
					end else begin
						done = 1'b1;
					end
				end
				cte_pkg::S_WR: begin
					if (op_r == `CTE_OP_MOV_DIR_TO_IDX || op_r == `CTE_OP_MOV_IDX_TO_DIR) begin
						hx_nxt = hx_r + `CTE_ONE16;
					end
					done = 1'b1;
				end
				cte_pkg::S_EXEC: begin
					case (op_r)
						`CTE_OP_ACC_TO_FLAGS: flag_nxt = a_r | `CTE_FLAG_ONES;
						`CTE_OP_SP_TO_INDEX: hx_nxt = sp_r + `CTE_ONE16;
						`CTE_OP_INDEX_TO_SP: sp_nxt = hx_r - `CTE_ONE16;
						default: flag_nxt = flag_r;
					endcase
					done = 1'b1;
				end
				cte_pkg::S_BR: begin
					pc_nxt = br_target;
					done = 1'b1;
				end
				cte_pkg::S_TRAP: begin
					step_nxt = step_r + 3'h1;
					case (step_r)
						`CTE_TRAP_LO: begin
							sp_nxt = sp_r - `CTE_ONE16;
							mem_nxt.wdata = pc_r[15:8];
						end
						`CTE_TRAP_HI: begin
							sp_nxt = sp_r - `CTE_ONE16;
							mem_nxt.wdata = hx_r[7:0];
						end
						`CTE_TRAP_X: begin
							sp_nxt = sp_r - `CTE_ONE16;
							mem_nxt.wdata = a_r;
						end
						`CTE_TRAP_A: begin
							sp_nxt = sp_r - `CTE_ONE16;
							mem_nxt.wdata = flag_r;
						end
						`CTE_TRAP_F: begin
							sp_nxt = sp_r - `CTE_ONE16;
							flag_nxt[`CTE_FLAG_I] = 1'b1;
							mode_nxt = cte_pkg::M_VEC_HI;
							mem_nxt.rd = 1'b1;
							mem_nxt.wr = 1'b0;
						end
						`CTE_TRAP_VH: begin
							data_nxt = mem_rdata_i;
							mode_nxt = cte_pkg::M_VEC_LO;
						end
						`CTE_TRAP_VL: begin
							pc_nxt = {data_r, mem_rdata_i};
							mode_nxt = cte_pkg::M_PC;
							mem_nxt.rd = 1'b0;
						end
						default: done = 1'b1;
					endcase
				end
				cte_pkg::S_WAIT: begin
					if (irq_i) begin
						done = 1'b1;
					end
				end
				default: done = 1'b1;
			endcase
			if (done) begin
				state_nxt = cte_pkg::S_FETCH;
				mode_nxt = cte_pkg::M_PC;
				mem_nxt.rd = 1'b1;
				mem_nxt.wr = 1'b0;
			end
			mem_nxt.addr = addr_nxt;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r <= cte_pkg::S_FETCH;
			mode_r <= cte_pkg::M_PC;
			mem_q <= '{RESET_PC, 1'b1, 1'b0, `CTE_BYTE0};
			step_r <= `CTE_TRAP_LO;
			op_r <= `CTE_BYTE0;
			pre_r <= 1'b0;
			pc_r <= RESET_PC;
			sp_r <= `CTE_SP_RST;
			hx_r <= 16'h0000;
			a_r <= `CTE_BYTE0;
			flag_r <= `CTE_FLAG_RST;
			off_r <= 16'h0000;
			data_r <= `CTE_BYTE0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			mode_r <= mode_nxt;
			mem_q <= mem_nxt;
			step_r <= step_nxt;
			op_r <= op_nxt;
			pre_r <= pre_nxt;
			pc_r <= pc_nxt;
			sp_r <= sp_nxt;
			hx_r <= hx_nxt;
			a_r <= a_nxt;
			flag_r <= flag_nxt;
			off_r <= off_nxt;
			data_r <= data_nxt;
		end
	end

	assign mem_req_o = mem_q;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic ahb_take;
	logic wpend_r, wpend_nxt;
	logic [31:0] waddr_r, waddr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;

	function automatic logic [31:0] reg_read(input logic [31:0] addr);
		case (addr)
			`CTE_A_CTRL: reg_read = {31'h0, run_r};
			`CTE_A_STATUS: reg_read = {15'h0, state_r == cte_pkg::S_WAIT, flag_r, a_r};
			`CTE_A_CORE: reg_read = {hx_r, sp_r};
			`CTE_A_PC: reg_read = {16'h0000, pc_r};
			default: reg_read = `CTE_WORD0;
		endcase
	endfunction : reg_read

	assign ahb_take = hsel_i && hready_i && htrans_i[1] && (hsize_i == `CTE_HSIZE_WORD);
	assign hreadyout_o = ce_i;
	assign hresp_o = 1'b0;
	assign hrdata_o = hrdata_r;

	always_comb begin : bus_next
		wpend_nxt = ahb_take && hwrite_i;
		waddr_nxt = ahb_take ? haddr_i : waddr_r;
		hrdata_nxt = (ahb_take && !hwrite_i) ? reg_read(haddr_i) : hrdata_r;
		run_nxt = run_r;
		if (wpend_r && waddr_r == `CTE_A_CTRL) begin
			run_nxt = hwdata_i[`CTE_CTRL_RUN];
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wpend_r <= 1'b0;
			waddr_r <= `CTE_WORD0;
			hrdata_r <= `CTE_WORD0;
			run_r <= `CTE_CTRL_RST;
		end else if (ce_i) begin
			wpend_r <= wpend_nxt;
			waddr_r <= waddr_nxt;
			hrdata_r <= hrdata_nxt;
			run_r <= run_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic fetch_go;
	assign fetch_go = go && (state_r == cte_pkg::S_FETCH);

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	a_trap_push_low: assert property (state_r == cte_pkg::S_TRAP && step_r == `CTE_TRAP_LO
		|-> mem_q.wr && mem_q.addr == sp_r && mem_q.wdata == pc_r[7:0])
		else $error("Trap does not push pc low first");
	a_trap_length: assert property ((fetch_go && mem_rdata_i == `CTE_OP_SOFT_TRAP)
		##1 go [*8] |=> state_r == cte_pkg::S_FETCH && flag_r[`CTE_FLAG_I])
		else $error("Trap not nine cycles or mask not set");
	a_trap_vector: assert property (state_r == cte_pkg::S_TRAP && step_r == `CTE_TRAP_VH
		|-> mem_q.rd && mem_q.addr == VEC_ADDR)
		else $error("Vector high byte not read");
	a_check_flags: assert property (state_r == cte_pkg::S_RD && go && is_check_op(op_r)
		|=> !flag_r[`CTE_FLAG_V] && flag_r[`CTE_FLAG_N] == $past(mem_rdata_i[7])
		&& flag_r[`CTE_FLAG_Z] == ($past(mem_rdata_i) == `CTE_BYTE0)
		&& flag_r[`CTE_FLAG_C] == $past(flag_r[`CTE_FLAG_C])
		&& flag_r[`CTE_FLAG_H] == $past(flag_r[`CTE_FLAG_H]))
		else $error("Check op flags wrong");
	a_check_acc_one: assert property (fetch_go && mem_rdata_i == `CTE_OP_ZNC_ACC
		|=> state_r == cte_pkg::S_FETCH && flag_r[`CTE_FLAG_N] == $past(a_r[7]))
		else $error("Accumulator check not one cycle");
	a_check_sp_four: assert property ((fetch_go && mem_rdata_i == `CTE_OP_PREBYTE)
		##1 (go && mem_rdata_i == `CTE_OP_ZNC_OFF8) ##1 go [*2] |=> state_r == cte_pkg::S_FETCH)
		else $error("Stack offset check not four cycles");
	a_sp_offset_addr: assert property (state_r == cte_pkg::S_RD && pre_r
		|-> mem_q.addr == sp_r + {`CTE_BYTE0, off_r[7:0]})
		else $error("Stack offset address wrong");
	a_wait_enter: assert property (fetch_go && mem_rdata_i == `CTE_OP_WAIT
		|=> state_r == cte_pkg::S_WAIT && !flag_r[`CTE_FLAG_I]
		&& (flag_r & `CTE_FLAG_KEEP_I) == ($past(flag_r) & `CTE_FLAG_KEEP_I))
		else $error("Wait entry or flags wrong");
	a_wait_hold: assert property (state_r == cte_pkg::S_WAIT && !irq_i
		|=> state_r == cte_pkg::S_WAIT && !mem_q.rd)
		else $error("Core left wait without interrupt");
	a_sp_to_index: assert property (state_r == cte_pkg::S_EXEC && go
		&& op_r == `CTE_OP_SP_TO_INDEX |=> hx_r == $past(sp_r) + `CTE_ONE16 && flag_r == $past(flag_r))
		else $error("Stack to index offset wrong");
	a_acc_to_flags: assert property ((fetch_go && mem_rdata_i == `CTE_OP_ACC_TO_FLAGS)
		##1 go |=> flag_r == ($past(a_r, 2) | `CTE_FLAG_ONES))
		else $error("Acc to flags wrong");
	a_move_postinc: assert property (state_r == cte_pkg::S_WR && go
		&& op_r == `CTE_OP_MOV_IDX_TO_DIR |=> hx_r == $past(hx_r) + `CTE_ONE16)
		else $error("Move did not increment index");
	a_branch_target: assert property (state_r == cte_pkg::S_BR && go
		|=> pc_r == $past(br_target))
		else $error("Branch target wrong");

	c_trap_done: cover property (state_r == cte_pkg::S_TRAP && step_r == `CTE_TRAP_END && go);
	c_wait_wake: cover property (state_r == cte_pkg::S_WAIT && go && irq_i);
	c_move_write: cover property (state_r == cte_pkg::S_WR && go);
	c_check_sp: cover property (state_r == cte_pkg::S_RD && pre_r && go);

endmodule : cte_core

// File: cte_mem_model.sv
`timescale 1ns/1ps

module cte_mem_model (
	input wire logic ref_clk_i,
	input wire logic ce_i,
	input wire cte_pkg::cte_mem_req_s req_i,
	output logic [7:0] rdata_o
);
	// ----------------------------------------
	// Byte store
	// ----------------------------------------
	logic [7:0] ram [0:65535];
	logic [7:0] last_r;

	// Idle cycles show a changing value, the complement of the previous cycle's value
	assign rdata_o = req_i.rd ? ram[req_i.addr] : ~last_r;

	always @(posedge ref_clk_i) begin
		if (ce_i && req_i.wr) begin
			ram[req_i.addr] <= req_i.wdata;
		end
		last_r <= rdata_o;
	end
endmodule : cte_mem_model

// File: tb_cpu08_isa_tail_execute.sv
`timescale 1ns/1ps

module tb_cpu08_isa_tail_execute;
	logic ref_clk_i, nrst_i, irq_i, hready, hresp, ce;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] mem_rdata;
	cte_pkg::cte_mem_req_s mem_req;
	int n_errors, comparisons, cyc, t_trap, t_vec;
	logic [111:0] prog0;
	logic [175:0] prog1;

	cte_core DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(ce), .irq_i(irq_i),
		.mem_rdata_i(mem_rdata), .mem_req_o(mem_req), .hsel_i(1'b1), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata));
	cte_mem_model MEM (.ref_clk_i(ref_clk_i), .ce_i(ce), .req_i(mem_req), .rdata_o(mem_rdata));

	// ----------------------------------------
	// Clock and cycle stamps
	// ----------------------------------------
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			cyc <= 0;
			t_trap <= -1;
			t_vec <= -1;
		end else begin
			cyc <= cyc + 1;
			if (mem_req.rd === 1'b1 && mem_req.addr === 16'h000d && t_trap < 0) begin
				t_trap <= cyc;
			end
			if (mem_req.rd === 1'b1 && mem_req.addr === 16'h0020 && t_vec < 0) begin
				t_vec <= cyc;
			end
		end
	end

	// ----------------------------------------
	// Report tasks
	// ----------------------------------------
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// ----------------------------------------
	// Bus master tasks
	// ----------------------------------------
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge ref_clk_i);
			i++;
		end while (hready !== 1'b1 && i < 50);
		if (hready !== 1'b1) begin
			n_errors++;
			$display("[ERR] hready expected 1 seen %b", hready);
			results();
		end
	endtask : wait_rdy

	task ahb_rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'b00;
		wait_rdy();
		d = hrdata;
	endtask : ahb_rd

	task ahb_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
	endtask : ahb_wr

	task chk_reg(input string name, input logic [31:0] a, input logic [31:0] exp);
		ahb_rd(a, rd);
		chk(name, exp, rd);
		chk("hresp", 32'h0000_0000, {31'h0, hresp});
	endtask : chk_reg

	// Wake the core from wait, let it run 20 cycles to the next wait, check status
	task wake_chk(input string name, input logic [31:0] exp);
		@(posedge ref_clk_i);
		irq_i <= 1'b1;
		@(posedge ref_clk_i);
		irq_i <= 1'b0;
		repeat (20) @(posedge ref_clk_i);
		chk_reg(name, 32'h0000_0004, exp);
	endtask : wake_chk

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n_errors = 0;
		comparisons = 0;
		nrst_i = 1'b0;
		ce = 1'b1;
		irq_i = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		for (int i = 0; i < 65536; i++) begin
			MEM.ram[i] = 8'h00;
		end
		prog0 = 112'h6e80_4085_977e_505e_513d_4095_9483;
		prog1 = 176'h8f9e_6d04_2002_8585_8f7d_8f9f_4d8f_6d03_8597_5d8f_848f;
		for (int i = 0; i < 14; i++) begin
			MEM.ram[i] = prog0[111 - 8 * i -: 8];
		end
		for (int i = 0; i < 22; i++) begin
			MEM.ram[16'h0020 + i] = prog1[175 - 8 * i -: 8];
		end
		MEM.ram[16'h0068] = 8'h5a;
		MEM.ram[16'h0100] = 8'h80;
		MEM.ram[16'h0103] = 8'hff;
		MEM.ram[16'h0051] = 8'ha5;
		MEM.ram[16'hfffc] = 8'h00;
		MEM.ram[16'hfffd] = 8'h20;
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;

		// Run to the first wait
		rd = 32'h0000_0000;
		for (int i = 0; i < 50 && rd[16] !== 1'b1; i++) begin
			ahb_rd(32'h0000_0004, rd);
		end
		chk("status_wait1", 32'h0001_6468, rd);
		chk("trap_cycles", 32'd9, t_vec - t_trap);
		chk("mov_imm", 32'h80, MEM.ram[16'h0040]);
		chk("mov_idx_dir", 32'h5a, MEM.ram[16'h0050]);
		chk("mov_dir_idx", 32'ha5, MEM.ram[16'h0069]);
		chk("push_pcl", 32'h0e, MEM.ram[16'h00ff]);
		chk("push_pch", 32'h00, MEM.ram[16'h00fe]);
		chk("push_x", 32'h00, MEM.ram[16'h00fd]);
		chk("push_acc", 32'h68, MEM.ram[16'h00fc]);
		chk("push_flags", 32'h6c, MEM.ram[16'h00fb]);
		chk_reg("core_wait1", 32'h0000_0008, 32'h0100_00fa);
		$display("test trap_and_wait done");

		// Wake, stack-offset check, branch, second wait
		wake_chk("status_wait2", 32'h0001_6268);
		chk_reg("core_wait2", 32'h0000_0008, 32'h0100_00fa);
		$display("test wake_branch done");

		// Remaining check forms and register copies, one wait apart
		wake_chk("status_idx", 32'h0001_6468);
		wake_chk("status_acc", 32'h0001_6200);
		wake_chk("status_xlo", 32'h0001_6064);
		chk_reg("core_xlo", 32'h0000_0008, 32'h0164_00fa);
		wake_chk("status_accflags", 32'h0001_6464);
		$display("test check_forms done");

		// Register access
		chk_reg("unmapped", 32'h0000_0010, 32'h0000_0000);
		ahb_wr(32'h0000_0000, 32'h0000_0000);
		chk_reg("ctrl_off", 32'h0000_0000, 32'h0000_0000);
		ahb_wr(32'h0000_0004, 32'hffff_ffff);
		chk_reg("status_ro", 32'h0000_0004, 32'h0001_6464);
		ahb_wr(32'h0000_0000, 32'h0000_0001);
		chk_reg("ctrl_on", 32'h0000_0000, 32'h0000_0001);
		$display("test registers done");

		// Clock enable low: bus stalls, interrupt cannot wake the core
		@(posedge ref_clk_i);
		ce <= 1'b0;
		irq_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		chk("hready_frozen", 32'h0000_0000, {31'h0, hready});
		ce <= 1'b1;
		irq_i <= 1'b0;
		chk_reg("status_frozen", 32'h0000_0004, 32'h0001_6464);
		$display("test clock_enable done");
		results();
	end
endmodule : tb_cpu08_isa_tail_execute
